// ===== core/pulse_counter.sv
// Pulse counter with quantity, rate, warm-up and AXI4-Lite registers
//
// Summary of operation
// - Each detected pulse adds one; the 32-bit total wraps to zero past its maximum.
// - Counting never stops, sleep or not; no pulse is dropped.
// - The total survives a main supply swap and resumes from the kept value.
// - The pulse pin is edge captured and raises a wake request.
// - A register write loads the total; writing zero clears it.
// - With midnight clear enabled each midnight tick zeroes the total, except when a register write loads it in that cycle.
// - Quantity is the pulses counted since the last log point, kept across loads, restarted each interval.
// - Quantity runs up between log points; the end-of-interval value is what gets logged.
// - Rate comes from the spacing of the last two pulses, scaled to one hour.
// - Pulses convert to units by a units-per-pulse factor that starts at one.
// - With log-each-change on, every change of the total emits a log entry.
// - Sensor power warms up for a set delay before measuring, never over the limit.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pulse_counter_consts.svh"
module pulse_counter
#(
   parameter int TICKS_PER_HOUR = `PC_MS_PER_H  // Rate time-base ticks per hour
)
(
   input  wire logic        aclk,           // System clock, 100 MHz
   input  wire logic        aresetn,        // Backup-domain reset, active low
   input  wire logic [7:0]  s_axi_awaddr,   // Write address
   input  wire logic        s_axi_awvalid,  // Write address valid
   output logic             s_axi_awready,  // Write address ready
   input  wire logic [31:0] s_axi_wdata,    // Write data
   input  wire logic [3:0]  s_axi_wstrb,    // Write byte enables
   input  wire logic        s_axi_wvalid,   // Write data valid
   output logic             s_axi_wready,   // Write data ready
   output logic [1:0]       s_axi_bresp,    // Write response
   output logic             s_axi_bvalid,   // Write response valid
   input  wire logic        s_axi_bready,   // Write response ready
   input  wire logic [7:0]  s_axi_araddr,   // Read address
   input  wire logic        s_axi_arvalid,  // Read address valid
   output logic             s_axi_arready,  // Read address ready
   output logic [31:0]      s_axi_rdata,    // Read data
   output logic [1:0]       s_axi_rresp,    // Read response
   output logic             s_axi_rvalid,   // Read data valid
   input  wire logic        s_axi_rready,   // Read data ready
   input  wire logic        pulse_pin,      // Reed contact input, asynchronous
   input  wire logic        tick_ms,        // Millisecond tick, one cycle
   input  wire logic        tick_sec,       // Second tick, one cycle
   input  wire logic        log_tick,       // Log interval boundary, one cycle
   input  wire logic        midnight_tick,  // Midnight, one cycle
   input  wire logic        meas_req,       // Measurement request, one cycle
   output logic             sensor_power,   // Sensor power switch on
   output logic             meas_ready,     // Warm-up over, one cycle
   output logic             log_entry,      // Record a change entry, one cycle
   output logic             wake,           // Wake request on a pulse, one cycle
   output logic             irq             // Interrupt, level
);
   logic        pulse;
   logic [31:0] div_quot;

   // Pin capture works without any bus activity, so pulses land during sleep
   pulse_input_sync u_sync
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (pulse_pin),
      .level   (),
      .rise    (pulse)
   );

   logic [31:0] count_reg, count_next, base_reg, base_next, qty_reg, qty_next;
   logic [31:0] logged_reg, logged_next, factor_reg, factor_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] load_val, base_adj, qty_cur, wmask;
   logic [`PC_EV_N-1:0] stat_reg, stat_next, mask_reg, mask_next, ev;
   logic        wr_do, rd_do, wr_count;
   logic [7:0]  awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0]  wstrb_reg, wstrb_next;
   logic        aw_held_reg, aw_held_next, w_held_reg, w_held_next;
   logic        awrdy_reg, awrdy_next, wrdy_reg, wrdy_next;
   logic        bvalid_reg, bvalid_next, arrdy_reg, arrdy_next, rvalid_reg, rvalid_next;
   logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next, rd_val;
   logic        rd_hit, wr_hit;
   logic        log_entry_reg, log_entry_next, wake_reg, irq_reg, irq_next;

   // Byte-lane mask from the held strobes
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
      end
   end

   // Write channel: address and data are taken in either order
   always_comb
   begin
      aw_held_next = aw_held_reg;
      w_held_next  = w_held_reg;
      awaddr_next  = awaddr_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      wr_do        = aw_held_reg & w_held_reg & ~bvalid_reg;
      wr_hit       = (awaddr_reg[7:2] <= `PC_OFS_MASK >> 2)
                     && (awaddr_reg[7:2] != `PC_OFS_QTY >> 2)
                     && (awaddr_reg[7:2] != `PC_OFS_LOGGED >> 2)
                     && (awaddr_reg[7:2] != `PC_OFS_RATE >> 2)
                     && (awaddr_reg[7:2] != `PC_OFS_STATUS >> 2);
      if (s_axi_awvalid && awrdy_reg)
      begin
         aw_held_next = 1'b1;
         awaddr_next  = s_axi_awaddr;
      end
      if (s_axi_wvalid && wrdy_reg)
      begin
         w_held_next = 1'b1;
         wdata_next  = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
      end
      if (wr_do)
      begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_hit ? `PC_RESP_OKAY : `PC_RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
         bvalid_next = 1'b0;
      end
      awrdy_next = ~aw_held_next & ~bvalid_next;
      wrdy_next  = ~w_held_next & ~bvalid_next;
   end

   // Read mux; all eight registers are readable, any other offset answers SLVERR
   always_comb
   begin
      rd_hit = 1'b1;
      case (s_axi_araddr[7:2])
         `PC_OFS_COUNT  >> 2: rd_val = count_reg;
         `PC_OFS_QTY    >> 2: rd_val = qty_reg;
         `PC_OFS_LOGGED >> 2: rd_val = logged_reg;
         `PC_OFS_RATE   >> 2: rd_val = div_quot;
         `PC_OFS_FACTOR >> 2: rd_val = factor_reg;
         `PC_OFS_CTRL   >> 2: rd_val = ctrl_reg;
         `PC_OFS_STATUS >> 2: rd_val = {{(32-`PC_EV_N){1'b0}}, stat_reg};
         `PC_OFS_MASK   >> 2: rd_val = {{(32-`PC_EV_N){1'b0}}, mask_reg};
         default:
         begin
            rd_val = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Read channel: one outstanding read, answered one cycle after acceptance
   always_comb
   begin
      rd_do       = s_axi_arvalid & arrdy_reg;
      rvalid_next = rvalid_reg;
      arrdy_next  = arrdy_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (rd_do)
      begin
         rvalid_next = 1'b1;
         arrdy_next  = 1'b0;
         rdata_next  = rd_val;
         rresp_next  = rd_hit ? `PC_RESP_OKAY : `PC_RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready)
      begin
         rvalid_next = 1'b0;
         arrdy_next  = 1'b1;
      end
   end

   // Counter, log base and quantity
   always_comb
   begin
      wr_count = wr_do & (awaddr_reg == `PC_OFS_COUNT);
      qty_cur  = count_reg - base_reg;
      load_val = count_reg;
      if (wr_count)
      begin
         load_val = (count_reg & ~wmask) | (wdata_reg & wmask);
      end
      else if (midnight_tick && ctrl_reg[`PC_CTRL_MIDNIGHT])
      begin
         load_val = 32'h00000000;
      end
      // A pulse in the same cycle as a load is added on top, not lost
      count_next = load_val + {31'h00000000, pulse};
      // Rebase so a load keeps the quantity already run up
      base_adj    = load_val - qty_cur;
      base_next   = base_adj;
      logged_next = logged_reg;
      if (log_tick)
      begin
         logged_next = count_next - base_adj;
         base_next   = count_next;
      end
      qty_next       = count_next - base_next;
      log_entry_next = ctrl_reg[`PC_CTRL_LOGCHG] & (count_next != count_reg);
   end

   // Configuration registers honour byte enables
   always_comb
   begin
      factor_next = factor_reg;
      ctrl_next   = ctrl_reg;
      mask_next   = mask_reg;
      if (wr_do && awaddr_reg == `PC_OFS_FACTOR)
      begin
         factor_next = (factor_reg & ~wmask) | (wdata_reg & wmask);
      end
      if (wr_do && awaddr_reg == `PC_OFS_CTRL)
      begin
         ctrl_next = ((ctrl_reg & ~wmask) | (wdata_reg & wmask)) & `PC_CTRL_WMASK;
      end
      if (wr_do && awaddr_reg == `PC_OFS_MASK)
      begin
         mask_next = (mask_reg & ~wmask[`PC_EV_N-1:0]) | (wdata_reg[`PC_EV_N-1:0]
                     & wmask[`PC_EV_N-1:0]);
      end
   end

   // Counter registers; only the backup-domain reset clears them
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_reg     <= 32'h00000000;
         base_reg      <= 32'h00000000;
         qty_reg       <= 32'h00000000;
         logged_reg    <= 32'h00000000;
         factor_reg    <= `PC_FACTOR_RST;
         ctrl_reg      <= 32'h00000000;
         mask_reg      <= '0;
         log_entry_reg <= 1'b0;
         wake_reg      <= 1'b0;
      end
      else
      begin
         count_reg     <= count_next;
         base_reg      <= base_next;
         qty_reg       <= qty_next;
         logged_reg    <= logged_next;
         factor_reg    <= factor_next;
         ctrl_reg      <= ctrl_next;
         mask_reg      <= mask_next;
         log_entry_reg <= log_entry_next;
         wake_reg      <= pulse;
      end
   end

   // Rate: millisecond spacing between pulses, divided into factor per hour
   logic [31:0] gap_reg, gap_next, den;
   logic [1:0]  seen_reg, seen_next;
   logic        div_start;
   logic [63:0] div_num;

   always_comb
   begin
      gap_next  = gap_reg;
      seen_next = seen_reg;
      if (tick_ms && gap_reg != `PC_COUNT_MAX)
      begin
         gap_next = gap_reg + 32'h00000001;
      end
      // A zero spacing is treated as one tick to keep the divisor nonzero
      den       = (gap_reg == 32'h00000000) ? 32'h00000001 : gap_reg;
      div_start = pulse & (seen_reg != 2'h0);
      if (pulse)
      begin
         gap_next = 32'h00000000;
         if (seen_reg != 2'h2)
         begin
            seen_next = seen_reg + 2'h1;
         end
      end
      div_num = {32'h00000000, factor_reg} * 64'(TICKS_PER_HOUR);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gap_reg  <= 32'h00000000;
         seen_reg <= 2'h0;
      end
      else
      begin
         gap_reg  <= gap_next;
         seen_reg <= seen_next;
      end
   end

   // Rate divider holds zero from reset until the second pulse completes
   rate_divider #(.NUM_W(64), .DEN_W(32), .Q_W(32)) u_div
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (div_start),
      .num     (div_num),
      .den     (den),
      .done    (),
      .quot    (div_quot)
   );

   // Warm-up timer counts second ticks with sensor power on
   pulse_counter_pkg::warm_state_t warm_reg, warm_next;
   logic [`PC_CTRL_DLY_W-1:0] dly, wsec_reg, wsec_next;
   logic                      pwr_reg, pwr_next, ready_reg, ready_next;

   always_comb
   begin
      dly = ctrl_reg[`PC_CTRL_DLY_LSB +: `PC_CTRL_DLY_W];
      if (dly > `PC_CTRL_DLY_W'(`PC_WARM_MAX_S))
      begin
         dly = `PC_CTRL_DLY_W'(`PC_WARM_MAX_S);
      end
      warm_next  = warm_reg;
      wsec_next  = wsec_reg;
      ready_next = 1'b0;
      case (warm_reg)
         pulse_counter_pkg::WARM_IDLE:
         begin
            if (meas_req)
            begin
               if (dly == '0)
               begin
                  ready_next = 1'b1;
               end
               else
               begin
                  warm_next = pulse_counter_pkg::WARM_ON;
                  wsec_next = '0;
               end
            end
         end
         pulse_counter_pkg::WARM_ON:
         begin
            if (tick_sec)
            begin
               wsec_next = wsec_reg + 1'b1;
               if (wsec_next >= dly)
               begin
                  warm_next  = pulse_counter_pkg::WARM_IDLE;
                  ready_next = 1'b1;
               end
            end
         end
         default: warm_next = pulse_counter_pkg::WARM_IDLE;
      endcase
      pwr_next = (warm_next == pulse_counter_pkg::WARM_ON);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         warm_reg  <= pulse_counter_pkg::WARM_IDLE;
         wsec_reg  <= '0;
         pwr_reg   <= 1'b0;
         ready_reg <= 1'b0;
      end
      else
      begin
         warm_reg  <= warm_next;
         wsec_reg  <= wsec_next;
         pwr_reg   <= pwr_next;
         ready_reg <= ready_next;
      end
   end

   // Sticky events; a read of status clears them but a new event wins
   always_comb
   begin
      ev = '0;
      ev[`PC_EV_PULSE]  = pulse;
      ev[`PC_EV_CHANGE] = log_entry_next;
      ev[`PC_EV_LOGPT]  = log_tick;
      ev[`PC_EV_WARM]   = ready_next;
      ev[`PC_EV_WRAP]   = pulse & (load_val == `PC_COUNT_MAX);
      stat_next = stat_reg;
      if (rd_do && s_axi_araddr[7:2] == (`PC_OFS_STATUS >> 2))
      begin
         stat_next = '0;
      end
      stat_next = stat_next | ev;
      irq_next  = |(stat_next & mask_next);
   end

   // Bus and interrupt registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h00000000;
         wstrb_reg   <= 4'h0;
         awrdy_reg   <= 1'b0;
         wrdy_reg    <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `PC_RESP_OKAY;
         arrdy_reg   <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h00000000;
         rresp_reg   <= `PC_RESP_OKAY;
         stat_reg    <= '0;
         irq_reg     <= 1'b0;
      end
      else
      begin
         aw_held_reg <= aw_held_next;
         w_held_reg  <= w_held_next;
         awaddr_reg  <= awaddr_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         awrdy_reg   <= awrdy_next;
         wrdy_reg    <= wrdy_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         arrdy_reg   <= ~rd_do & (arrdy_next | ~rvalid_next);
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
         stat_reg    <= stat_next;
         irq_reg     <= irq_next;
      end
   end

   assign s_axi_awready = awrdy_reg;
   assign s_axi_wready  = wrdy_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arrdy_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign sensor_power  = pwr_reg;
   assign meas_ready    = ready_reg;
   assign log_entry     = log_entry_reg;
   assign wake          = wake_reg;
   assign irq           = irq_reg;
endmodule

// ===== core/pulse_input_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`include "pulse_counter_consts.svh"
module pulse_input_sync
(
   input  wire logic aclk,     // System clock
   input  wire logic aresetn,  // Synchronous reset, active low
   input  wire logic pin,      // Asynchronous contact input
   output logic      level,    // Filtered input level
   output logic      rise      // One-cycle pulse on each closure
);
   logic s1_reg, s2_reg, s3_reg, lvl_reg, rise_reg;
   logic lvl_next, rise_next;

   // A change counts only once stages two and three agree
   always_comb
   begin
      lvl_next  = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
      rise_next = lvl_next & ~lvl_reg;
   end

   // Stage one feeds stage two only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_reg   <= 1'b0;
         s2_reg   <= 1'b0;
         s3_reg   <= 1'b0;
         lvl_reg  <= 1'b0;
         rise_reg <= 1'b0;
      end
      else
      begin
         s1_reg   <= pin;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         lvl_reg  <= lvl_next;
         rise_reg <= rise_next;
      end
   end

   assign level = lvl_reg;
   assign rise  = rise_reg;
endmodule

// ===== core/rate_divider.sv
// Iterative restoring divider, one quotient bit per clock, saturating result
`timescale 1ns/1ps
module rate_divider
#(
   parameter int NUM_W = 64,  // Dividend width
   parameter int DEN_W = 32,  // Divisor width
   parameter int Q_W   = 32   // Result width
)
(
   input  wire logic             aclk,     // System clock
   input  wire logic             aresetn,  // Synchronous reset, active low
   input  wire logic             start,    // Start pulse, restarts a busy run
   input  wire logic [NUM_W-1:0] num,      // Dividend
   input  wire logic [DEN_W-1:0] den,      // Divisor, nonzero
   output logic                  done,     // One-cycle pulse with new result
   output logic      [Q_W-1:0]   quot      // Registered quotient
);
   localparam int CNT_W = $clog2(NUM_W) + 1;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(NUM_W - 1);

   logic [NUM_W-1:0] work_reg, work_next;
   logic [DEN_W:0]   rem_reg, rem_next, rem_sh;
   logic [DEN_W-1:0] den_reg, den_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic             busy_reg, busy_next, done_reg, done_next;
   logic [Q_W-1:0]   quot_reg, quot_next;
   logic             qbit;

   // Shift-subtract step; a result too wide for the output saturates
   always_comb
   begin
      rem_sh    = {rem_reg[DEN_W-1:0], work_reg[NUM_W-1]};
      qbit      = (rem_sh >= {1'b0, den_reg});
      work_next = work_reg;
      rem_next  = rem_reg;
      den_next  = den_reg;
      cnt_next  = cnt_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      quot_next = quot_reg;
      if (start)
      begin
         work_next = num;
         rem_next  = '0;
         den_next  = den;
         cnt_next  = '0;
         busy_next = 1'b1;
      end
      else if (busy_reg)
      begin
         rem_next  = qbit ? (rem_sh - {1'b0, den_reg}) : rem_sh;
         work_next = {work_reg[NUM_W-2:0], qbit};
         cnt_next  = cnt_reg + 1'b1;
         if (cnt_reg == LAST)
         begin
            busy_next = 1'b0;
            done_next = 1'b1;
            quot_next = (|work_next[NUM_W-1:Q_W]) ? '1 : work_next[Q_W-1:0];
         end
      end
   end

   // Divider state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         work_reg <= '0;
         rem_reg  <= '0;
         den_reg  <= '0;
         cnt_reg  <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         quot_reg <= '0;
      end
      else
      begin
         work_reg <= work_next;
         rem_reg  <= rem_next;
         den_reg  <= den_next;
         cnt_reg  <= cnt_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         quot_reg <= quot_next;
      end
   end

   assign done = done_reg;
   assign quot = quot_reg;
endmodule

// ===== dv/pulse_counter_monitor.sv
// Port checker for the pulse counter
`timescale 1ns/1ps
module pulse_counter_monitor
(
   input wire logic aclk,          // Clock
   input wire logic aresetn,       // Reset
   input wire logic pulse_pin,     // Contact
   input wire logic tick_sec,      // Second tick
   input wire logic meas_req,      // Request
   input wire logic sensor_power,  // Power
   input wire logic meas_ready,    // Ready
   input wire logic wake,          // Wake
   input wire logic s_axi_bvalid,  // B valid
   input wire logic s_axi_bready,  // B ready
   input wire logic s_axi_rvalid,  // R valid
   input wire logic s_axi_rready   // R ready
);
   logic [9:0] sec_reg;
   logic [9:0] sec_next;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Seconds powered; the ceiling guards battery life
   always_comb sec_next = sensor_power ? sec_reg + {9'h000, tick_sec} : 10'h000;
   always_ff @(posedge aclk) sec_reg <= aresetn ? sec_next : 10'h000;
   sequence s_close; $rose(pulse_pin); endsequence
   sequence s_end; $fell(sensor_power) ##0 meas_ready; endsequence
   property p_wake; s_close |-> ##[2:10] wake; endproperty
   property p_one; wake |=> !wake; endproperty
   property p_on; $rose(sensor_power) |-> $past(meas_req); endproperty
   property p_off; $fell(sensor_power) |-> s_end; endproperty
   property p_hold; sensor_power && !tick_sec |=> sensor_power; endproperty
   property p_max; sec_reg <= 10'h12C; endproperty
   property p_b; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   property p_r; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   a_one: assert property (p_one) else $error("long wake");
   a_on: assert property (p_on) else $error("power unasked");
   a_off: assert property (p_off) else $error("no ready");
   a_hold: assert property (p_hold) else $error("power drop");
   a_max: assert property (p_max) else $error("warm too long");
   a_b: assert property (p_b) else $error("b stuck");
   a_r: assert property (p_r) else $error("r stuck");
endmodule

// ===== dv/reed_contact_model.sv
// Reed contact sensor that closes briefly per tip
`timescale 1ns/1ps
module reed_contact_model
(
   input  wire logic aclk,  // Clock
   input  wire logic fire,  // Tip request
   output logic      pin    // Contact, pulled low when open
);
   logic [2:0] hold_reg = 3'h0;
   logic [2:0] hold_next;
   // Six clocks closed, above the two-clock minimum
   always_comb hold_next = fire ? 3'h6 : hold_reg - {2'h0, hold_reg != 3'h0};
   always_ff @(posedge aclk) hold_reg <= hold_next;
   assign pin = hold_reg != 3'h0;
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the pulse counter
`timescale 1ns/1ps
`include "pulse_counter_consts.svh"
module tb_top;
   logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0;
   logic        arv = 1'b0, rr = 1'b0, fire = 1'b0, awr, wr_r, bv, arr, rv, pin, lent, irq;
   logic [4:0]  tk = 5'h00;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h00000000, rdat, v;
   logic [1:0]  bresp, rresp;
   logic [33:0] qr[$];
   logic [1:0]  qb[$];
   logic [15:0] sd = 16'hF060;
   int          errors = 0, checked = 0, nlog = 0;
   pulse_counter #(.TICKS_PER_HOUR(1000)) pulse_counter_i
   (
      .aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .pulse_pin(pin), .tick_ms(tk[0]),
      .tick_sec(tk[1]), .log_tick(tk[2]), .midnight_tick(tk[3]), .meas_req(tk[4]),
      .sensor_power(), .meas_ready(), .log_entry(lent), .wake(), .irq(irq)
   );
   reed_contact_model reed_contact_model_i (.aclk, .fire, .pin);
   always #5 aclk = ~aclk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task complete_run;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Bus write; the response is judged by the watcher below
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      qb.push_back(r);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
      end
      while (!bv);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      qr.push_back({r, d});
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end
      while (!rv);
   endtask
   task pls(input int n);
      repeat (n)
      begin
         fire <= 1'b1;
         @(posedge aclk);
         fire <= 1'b0;
         repeat (15) @(posedge aclk);
      end
   endtask
   // Ticks: 0 ms, 1 second, 2 log, 3 midnight, 4 measure
   task tick(input int b, input int n);
      repeat (n)
      begin
         tk[b] <= 1'b1;
         @(posedge aclk);
         tk[b] <= 1'b0;
         repeat (3) @(posedge aclk);
      end
   endtask
   // Watcher pairs each answer with the oldest note
   always @(posedge aclk)
   begin
      if (lent) nlog++;
      if (bv && br) chk({32'h0, bresp}, {32'h0, qb.pop_front()});
      if (rv && rr) chk({rresp, rdat}, qr.pop_front());
   end
   initial
   begin
      repeat (20000) @(posedge aclk);
      errors++;
      complete_run;
   end
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`PC_OFS_FACTOR, `PC_FACTOR_RST);
      pls(1);
      rd(`PC_OFS_RATE, 32'h00000000);
      tick(0, 10);
      pls(1);
      repeat (70) @(posedge aclk);
      rd(`PC_OFS_RATE, 32'h00640000);
      rd(`PC_OFS_QTY, 32'h00000002);
      tick(2, 1);
      rd(`PC_OFS_LOGGED, 32'h00000002);
      rd(`PC_OFS_QTY, 32'h00000000);
      sd = lfsr(sd);
      v = {sd, lfsr(sd)};
      wr(`PC_OFS_COUNT, v);
      pls(1);
      rd(`PC_OFS_COUNT, v + 32'h00000001);
      wr(`PC_OFS_COUNT, 32'hFFFFFFFE);
      pls(3);
      rd(`PC_OFS_COUNT, 32'h00000001);
      rd(`PC_OFS_QTY, 32'h00000004);
      wr(`PC_OFS_CTRL, 32'h00000001);
      tick(3, 1);
      rd(`PC_OFS_COUNT, 32'h00000000);
      wr(`PC_OFS_CTRL, 32'h00000002);
      pls(2);
      wr(`PC_OFS_CTRL, 32'h00020000);
      chk(34'(nlog), 34'h2);
      rd(`PC_OFS_STATUS, 32'h00000017);
      wr(`PC_OFS_MASK, 32'h00000008);
      tick(4, 1);
      tick(1, 2);
      chk({33'h0, irq}, 34'h1);
      rd(`PC_OFS_STATUS, 32'h00000008);
      repeat (2) @(posedge aclk);
      chk({33'h0, irq}, 34'h0);
      rd(8'h20, 32'h00000000, `PC_RESP_SLVERR);
      wr(`PC_OFS_QTY, 32'h00000005, `PC_RESP_SLVERR);
      rd(`PC_OFS_QTY, 32'h00000006);
      complete_run;
   end
endmodule
bind pulse_counter pulse_counter_monitor pulse_counter_monitor_i (.aclk, .aresetn, .pulse_pin,
   .tick_sec, .meas_req, .sensor_power, .meas_ready, .wake, .s_axi_bvalid, .s_axi_bready,
   .s_axi_rvalid, .s_axi_rready);

// ===== inc/pulse_counter_consts.svh
// Register offsets, field positions, reset values and limits of the pulse counter
`ifndef PULSE_COUNTER_CONSTS_SVH
`define PULSE_COUNTER_CONSTS_SVH

`define PC_OFS_COUNT      8'h00
`define PC_OFS_QTY        8'h04
`define PC_OFS_LOGGED     8'h08
`define PC_OFS_RATE       8'h0C
`define PC_OFS_FACTOR     8'h10
`define PC_OFS_CTRL       8'h14
`define PC_OFS_STATUS     8'h18
`define PC_OFS_MASK       8'h1C

// Control word fields
`define PC_CTRL_MIDNIGHT  0
`define PC_CTRL_LOGCHG    1
`define PC_CTRL_DLY_LSB   16
`define PC_CTRL_DLY_W     9
`define PC_CTRL_WMASK     32'h01FF0003

// Status and mask bit positions
`define PC_EV_PULSE       0
`define PC_EV_CHANGE      1
`define PC_EV_LOGPT       2
`define PC_EV_WARM        3
`define PC_EV_WRAP        4
`define PC_EV_N           5

// Units per pulse is 16.16 fixed point; one unit per pulse after reset
`define PC_FACTOR_RST     32'h00010000
`define PC_COUNT_MAX      32'hFFFFFFFF

// Warm-up limit in minutes, and the same in seconds
`define PC_WARM_MAX_MIN   5
`define PC_SEC_PER_MIN    60
`define PC_WARM_MAX_S     (`PC_WARM_MAX_MIN * `PC_SEC_PER_MIN)

// Rate time base: millisecond ticks per hour
`define PC_MS_PER_S       1000
`define PC_S_PER_H        3600
`define PC_MS_PER_H       (`PC_MS_PER_S * `PC_S_PER_H)

`define PC_RESP_OKAY      2'h0
`define PC_RESP_SLVERR    2'h2

`endif

// ===== inc/pulse_counter_pkg.sv
// Types shared by the pulse counter design
package pulse_counter_pkg;
   typedef enum logic {WARM_IDLE, WARM_ON} warm_state_t;
endpackage
